// *** aosd_dma.sv ***
// Summary of operation
// - samples go in order to lanes one..four
// - fetch word addresses never decrease within buffer
// - byte order bit selects big or little endian
// - two equal buffers used as double buffer
// - optional msb inversion of memory samples
// - idle lanes send zero, msb inverted when inversion is on
// - chip reset or 0x80000000 write resets unit
// - host processor reset leaves unit untouched
// - unit reset restores all fields to defaults
// - timestamp cleared by chip or host reset
// - after reset output off, buffer one current
// - drain buffer one, flag it, continue two
// - buffer one drained raises interrupt when enabled
// - length counts mono samples or stereo pairs
// - format field selects mono/stereo, 32/16 bit
// - mono sends sample as left and right
// - buffer two drains, flags, resumes buffer one
// - acknowledge clears drained flag, reads zero
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
module aosd_dma
(
   // clock and resets
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        host_reset_n,
   // axi4-lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // memory highway read port
   output logic             mem_req,
   output logic [31:0]      mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   // lane data towards the serial framer
   input  wire logic        frame_take,
   output logic [31:0]      lane_left  [4],
   output logic [31:0]      lane_right [4],
   output logic             frame_ready,
   // buffer-drained interrupt (source 12)
   output logic             drained_irq,
   // timestamp counter
   output logic [31:0]      cycle_count
);
   aosd_fetch_if fch();

   // memory port instance
   aosd_fetch_port u_port
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .fch       (fch),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_ack   (mem_ack),
      .mem_rdata (mem_rdata)
   );

   // ---- registers
   logic        output_run;            // transmit enable
   logic        little_endian;         // byte order
   logic        msb_invert;            // offset binary conversion
   logic [1:0]  sample_format_select;  // mono/stereo, width
   logic [1:0]  lane_count_select;     // lanes minus one
   logic        first_drained_irq_on;
   logic        second_drained_irq_on;
   logic        first_buffer_current;
   logic        first_buffer_drained;
   logic        second_buffer_drained;
   logic [31:0] first_buffer_base;
   logic [31:0] second_buffer_base;
   logic [31:0] buffer_length;

   // ---- bus decode
   logic        aw_held;               // write address captured
   logic        w_held;                // write data captured
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   assign s_awready = ~aw_held & ~s_bvalid;
   assign s_wready  = ~w_held & ~s_bvalid;
   wire do_write = aw_held & w_held & ~s_bvalid;
   wire wr_ctrl  = do_write && aw_addr == aosd_pkg::OFF_CTRL;
   wire wr_first_buffer_base = do_write && aw_addr == aosd_pkg::OFF_FIRST_BUFFER_BASE;
   wire wr_second_buffer_base = do_write && aw_addr == aosd_pkg::OFF_SECOND_BUFFER_BASE;
   wire wr_len   = do_write && aw_addr == aosd_pkg::OFF_LENGTH;
   wire wr_known = wr_ctrl | wr_first_buffer_base | wr_second_buffer_base | wr_len
                   | (do_write && aw_addr == aosd_pkg::OFF_STATUS);
   // full-word soft reset; a partial strobe cannot reset
   wire soft_reset = wr_ctrl && w_strb == 4'hF
                     && w_data == aosd_pkg::SOFT_RESET_WORD;
   // unit reset: chip pin or soft write, never host reset
   wire unit_rst = ~aresetn | soft_reset;
   wire first_buffer_acknowledge = wr_ctrl & w_data[aosd_pkg::CTL_FIRST_BUFFER_ACKNOWLEDGE_BIT] & w_strb[1];
   wire second_buffer_acknowledge = wr_ctrl & w_data[aosd_pkg::CTL_SECOND_BUFFER_ACKNOWLEDGE_BIT] & w_strb[1];

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      for (int i = 0; i < 4; i++)
         merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
   endfunction

   // bus write channel capture and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h0000_0000;
         w_strb   <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp  <= aosd_pkg::AXI_OKAY;
      end
      else
      begin
         if (s_awvalid & s_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr;
         end
         if (s_wvalid & s_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end
         if (do_write)
         begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= wr_known ? aosd_pkg::AXI_OKAY : aosd_pkg::AXI_SLVERR;
         end
         else if (s_bready)
            s_bvalid <= 1'b0;
      end
   end

   // control and configuration registers
   always_ff @(posedge aclk)
   begin
      if (unit_rst)
      begin
         // every field back to default
         output_run            <= 1'b0;
         little_endian         <= 1'b0; // big endian default
         msb_invert            <= 1'b0;
         sample_format_select  <= aosd_pkg::FMT_MONO32;
         lane_count_select     <= 2'b00;
         first_drained_irq_on  <= 1'b0;
         second_drained_irq_on <= 1'b0;
         first_buffer_base     <= 32'h0000_0000;
         second_buffer_base    <= 32'h0000_0000;
         buffer_length         <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ctrl & w_strb[0])
         begin
            output_run           <= w_data[aosd_pkg::CTL_RUN_BIT];
            little_endian        <= w_data[aosd_pkg::CTL_LITTLE_BIT];
            msb_invert           <= w_data[aosd_pkg::CTL_INVERT_BIT];
            sample_format_select <= w_data[aosd_pkg::CTL_FMT_LO +: 2];
            lane_count_select    <= w_data[aosd_pkg::CTL_LANE_LO +: 2];
            first_drained_irq_on <= w_data[aosd_pkg::CTL_IRQ1_BIT];
         end
         if (wr_ctrl & w_strb[1])
            second_drained_irq_on <= w_data[aosd_pkg::CTL_IRQ2_BIT];
         if (wr_first_buffer_base)
            first_buffer_base <= merge(first_buffer_base, w_data, w_strb);
         if (wr_second_buffer_base)
            second_buffer_base <= merge(second_buffer_base, w_data, w_strb);
         if (wr_len)
            buffer_length <= merge(buffer_length, w_data, w_strb);
      end
   end

   // ---- read channel
   wire [31:0] ctrl_rd = {23'h0,
      second_drained_irq_on, first_drained_irq_on, lane_count_select,
      sample_format_select, msb_invert, little_endian, output_run};
   wire [31:0] stat_rd = {29'h0, second_buffer_drained,
      first_buffer_drained, first_buffer_current};
   // acknowledge bits are write-only and read as zero
   wire [31:0] rd_mux =
      s_araddr == aosd_pkg::OFF_CTRL   ? ctrl_rd :
      s_araddr == aosd_pkg::OFF_STATUS ? stat_rd :
      s_araddr == aosd_pkg::OFF_FIRST_BUFFER_BASE  ? first_buffer_base :
      s_araddr == aosd_pkg::OFF_SECOND_BUFFER_BASE  ? second_buffer_base :
      s_araddr == aosd_pkg::OFF_LENGTH ? buffer_length : 32'h0000_0000;
   wire rd_known = s_araddr == aosd_pkg::OFF_CTRL
      || s_araddr == aosd_pkg::OFF_STATUS || s_araddr == aosd_pkg::OFF_FIRST_BUFFER_BASE
      || s_araddr == aosd_pkg::OFF_SECOND_BUFFER_BASE || s_araddr == aosd_pkg::OFF_LENGTH;
   assign s_arready = ~s_rvalid;

   // read data registered one cycle after address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= aosd_pkg::AXI_OKAY;
      end
      else if (s_arvalid & s_arready)
      begin
         s_rvalid <= 1'b1;
         s_rdata  <= rd_mux;
         s_rresp  <= rd_known ? aosd_pkg::AXI_OKAY : aosd_pkg::AXI_SLVERR;
      end
      else if (s_rready)
         s_rvalid <= 1'b0;
   end

   // ---- fetch engine
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_SHOW  = 2'b10
   } aosd_state_t;
   aosd_state_t state;
   logic [31:0] offset;     // byte offset inside current buffer
   logic [2:0]  slot;       // lane*2 + right
   logic [31:0] hold_left  [4];
   logic [31:0] hold_right [4];

   wire is16   = sample_format_select[1];
   wire stereo = sample_format_select[0];
   // six low bits ignored
   wire [31:0] base_now = (first_buffer_current ? first_buffer_base
      : second_buffer_base) & ~32'h0000_003F;
   wire [31:0] len_al = buffer_length & ~32'h0000_003F;
   // byte span: 2,4,4,8 times length
   wire [31:0] span = is16 ? (stereo ? len_al << 2 : len_al << 1)
                           : (stereo ? len_al << 3 : len_al << 2);
   wire [31:0] step = is16 ? 32'h0000_0002 : 32'h0000_0004;
   wire [31:0] next_offset = offset + step;
   wire        buf_end = next_offset >= span;
   // the current buffer needs to be full before fetching
   wire cur_full = first_buffer_current ? ~first_buffer_drained
                                        : ~second_buffer_drained;
   wire [2:0] last_slot = {lane_count_select, stereo};

   // halfword selection and byte order
   function automatic logic [31:0] shape(input logic [31:0] w,
      input logic [1:0] a, input logic h16, input logic le,
      input logic inv);
      logic [31:0] s;
      logic [15:0] hw;
      s  = 32'h0000_0000;
      hw = a[1] ? (le ? w[31:16] : w[15:0]) : (le ? w[15:0] : w[31:16]);
      if (h16)
         s = {16'h0000, le ? hw : {hw[7:0], hw[15:8]}};
      else
         s = le ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
      // msb flip for offset binary
      if (inv)
         s = h16 ? s ^ 32'h0000_8000 : s ^ 32'h8000_0000;
      return s;
   endfunction
   wire [31:0] sample = shape(fch.rdata, offset[1:0], is16,
                              little_endian, msb_invert);
   wire [31:0] idle_word = msb_invert ? (is16 ? 32'h0000_8000
      : 32'h8000_0000) : 32'h0000_0000;

   assign fch.req  = state == ST_FETCH & ~fch.ack;
   // word address never decreases within a buffer; 16-bit halves share a word
   assign fch.addr = base_now + {offset[31:2], 2'b00};
   assign fch.is16 = is16;
   assign frame_ready = state == ST_SHOW;

   // sample sequencer: fetch, route, then hand frame to framer
   always_ff @(posedge aclk)
   begin
      if (unit_rst)
      begin
         state                 <= ST_IDLE;
         offset                <= 32'h0000_0000;
         slot                  <= 3'd0;
         first_buffer_current  <= 1'b1;
         first_buffer_drained  <= 1'b0;
         second_buffer_drained <= 1'b0;
         for (int i = 0; i < 4; i++)
         begin
            hold_left[i]  <= 32'h0000_0000;
            hold_right[i] <= 32'h0000_0000;
            lane_left[i]  <= 32'h0000_0000;
            lane_right[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         if (first_buffer_acknowledge)
            first_buffer_drained <= 1'b0;
         if (second_buffer_acknowledge)
            second_buffer_drained <= 1'b0;
         unique case (state)
            ST_IDLE:
               if (output_run & cur_full)
               begin
                  state <= ST_FETCH;
                  slot  <= 3'd0;
               end
            ST_FETCH:
               if (fch.ack)
               begin
                  // route in lane order
                  if (stereo & slot[0])
                     hold_right[slot[2:1]] <= sample;
                  else
                  begin
                     hold_left[slot[2:1]] <= sample;
                     if (!stereo)
                        hold_right[slot[2:1]] <= sample;
                  end
                  if (buf_end)
                  begin
                     // switch buffers without gap
                     offset <= 32'h0000_0000;
                     first_buffer_current <= ~first_buffer_current;
                     if (first_buffer_current)
                        first_buffer_drained <= 1'b1; // set wins
                     else
                        second_buffer_drained <= 1'b1;
                  end
                  else
                     offset <= next_offset;
                  slot <= stereo ? slot + 3'd1 : slot + 3'd2;
                  if ({slot[2:1], stereo & slot[0]} == last_slot
                      || (!stereo && slot[2:1] == lane_count_select))
                     state <= ST_SHOW;
                  else if (buf_end & ~(first_buffer_current
                           ? ~second_buffer_drained : ~first_buffer_drained))
                     state <= ST_FETCH;
               end
            ST_SHOW:
               if (frame_take)
               begin
                  for (int i = 0; i < 4; i++)
                  begin
                     lane_left[i]  <= (2'(i) <= lane_count_select)
                                      ? hold_left[i] : idle_word;
                     lane_right[i] <= (2'(i) <= lane_count_select)
                                      ? hold_right[i] : idle_word;
                  end
                  state <= (output_run & cur_full) ? ST_FETCH : ST_IDLE;
                  slot  <= 3'd0;
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // interrupt level while drained flags enabled
   assign drained_irq = (first_buffer_drained & first_drained_irq_on)
                      | (second_buffer_drained & second_drained_irq_on);

   // timestamp: chip or host reset only, not soft reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !host_reset_n)
         cycle_count <= 32'h0000_0000;
      else
         cycle_count <= cycle_count + 32'h0000_0001;
   end

   // ---- assertions
   property p_soft_reset;
      @(posedge aclk) disable iff (!aresetn)
      soft_reset |=> !output_run && first_buffer_current
                     && !first_buffer_drained;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset did not restore defaults");

   property p_drain1;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_FETCH && fch.ack && buf_end && first_buffer_current
       && !soft_reset) |=> first_buffer_drained && !first_buffer_current;
   endproperty
   a_drain1: assert property (p_drain1)
      else $error("buffer one drain not flagged");

   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      (first_buffer_drained && first_drained_irq_on) |-> drained_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("drained interrupt missing");

   property p_ack_read;
      @(posedge aclk) disable iff (!aresetn)
      (s_arvalid && s_arready && s_araddr == aosd_pkg::OFF_CTRL)
      |=> s_rdata[aosd_pkg::CTL_SECOND_BUFFER_ACKNOWLEDGE_BIT:aosd_pkg::CTL_FIRST_BUFFER_ACKNOWLEDGE_BIT] == 2'b00;
   endproperty
   a_ack_read: assert property (p_ack_read)
      else $error("acknowledge bits read nonzero");

   property p_addr_up;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_FETCH && fch.ack && !buf_end && !soft_reset)
      |=> offset > $past(offset);
   endproperty
   a_addr_up: assert property (p_addr_up)
      else $error("fetch address did not increase");

   property p_host_keep;
      @(posedge aclk) disable iff (!aresetn)
      (!host_reset_n && !soft_reset && !wr_ctrl) |=> $stable(output_run);
   endproperty
   a_host_keep: assert property (p_host_keep)
      else $error("host reset disturbed unit");

   property p_ts_clear;
      @(posedge aclk) disable iff (!aresetn)
      !host_reset_n |=> cycle_count == 32'h0000_0000;
   endproperty
   a_ts_clear: assert property (p_ts_clear)
      else $error("timestamp not cleared");

   property p_idle_lane;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_SHOW && frame_take && lane_count_select == 2'b00
       && !soft_reset) |=> lane_left[3] == $past(idle_word);
   endproperty
   a_idle_lane: assert property (p_idle_lane)
      else $error("idle lane value wrong");

   property p_mono_dup;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_SHOW && frame_take && !stereo && !soft_reset)
      |=> lane_left[0] == lane_right[0];
   endproperty
   a_mono_dup: assert property (p_mono_dup)
      else $error("mono left and right differ");
endmodule

// *** aosd_fetch_if.sv ***
// memory fetch channel between the engine and its fetch port
interface aosd_fetch_if;
   logic        req;
   logic [31:0] addr;
   logic        is16;
   logic        ack;
   logic [31:0] rdata;
   modport engine (output req, output addr, output is16,
                   input ack, input rdata);
   modport port (input req, input addr, input is16,
                 output ack, output rdata);
endinterface

// *** aosd_fetch_port.sv ***
// memory side: forwards requests, registers returned words
module aosd_fetch_port
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // engine side
   aosd_fetch_if.port       fch,
   // memory side
   output logic             mem_req,
   output logic [31:0]      mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata
);
   // request is passed straight through, held by the engine
   assign mem_req  = fch.req;
   assign mem_addr = fch.addr;
   // returned data registered so the engine sees stable words
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fch.ack   <= 1'b0;
         fch.rdata <= 32'h0000_0000;
      end
      else
      begin
         fch.ack <= mem_ack & fch.req & ~fch.ack;
         if (mem_ack)
            fch.rdata <= mem_rdata;
      end
   end
endmodule

// *** aosd_mem_model.sv ***
module aosd_mem_model
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // highway read port
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;  // wait counter
   logic       slow; // alternates prompt and slow answers
   // byte-symmetric word: either byte order reads the same value
   function automatic logic [31:0] pat(input logic [31:0] a);
      return {a[9:2], ~a[9:2], ~a[9:2], a[9:2]};
   endfunction
   // one ack per request; data scrambles off the ack cycle
   always @(posedge aclk)
   begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!aresetn)
      begin
         cnt       <= 2'h0;
         slow      <= 1'b0;
         mem_rdata <= 32'h5555_aaaa;
      end
      else if (mem_req && !mem_ack)
      begin
         cnt <= cnt + 2'h1;
         // slow turns wait three extra cycles
         if (!slow || cnt == 2'h3)
         begin
            mem_ack   <= 1'b1;
            mem_rdata <= pat(mem_addr);
            cnt       <= 2'h0;
            slow      <= ~slow;
         end
      end
   end
endmodule

// *** aosd_pkg.sv ***
package aosd_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_FIRST_BUFFER_BASE  = 8'h08;
   localparam logic [7:0] OFF_SECOND_BUFFER_BASE  = 8'h0C;
   localparam logic [7:0] OFF_LENGTH = 8'h10;
   // control word fields
   localparam int CTL_RESET_BIT  = 31;
   localparam int CTL_RUN_BIT    = 0;
   localparam int CTL_LITTLE_BIT = 1;
   localparam int CTL_INVERT_BIT = 2;
   localparam int CTL_FMT_LO     = 3;
   localparam int CTL_LANE_LO    = 5;
   localparam int CTL_IRQ1_BIT   = 7;
   localparam int CTL_IRQ2_BIT   = 8;
   localparam int CTL_FIRST_BUFFER_ACKNOWLEDGE_BIT   = 9;
   localparam int CTL_SECOND_BUFFER_ACKNOWLEDGE_BIT   = 10;
   localparam logic [31:0] SOFT_RESET_WORD = 32'h8000_0000;
   // status fields
   localparam int ST_CUR1_BIT = 0;
   localparam int ST_DRN1_BIT = 1;
   localparam int ST_DRN2_BIT = 2;
   // alignment: six low address/size bits ignored
   localparam int ALIGN_BITS = 6;
   // sample formats
   typedef enum logic [1:0] {
      FMT_MONO32   = 2'b00,
      FMT_STEREO32 = 2'b01,
      FMT_MONO16   = 2'b10,
      FMT_STEREO16 = 2'b11
   } aosd_fmt_t;
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// *** test_audio_out_sample_dma.sv ***
module test_audio_out_sample_dma;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] B1 = 32'h0000_1000; // first buffer base
   localparam logic [31:0] B2 = 32'h0000_2100; // second buffer base
   // bench-driven inputs
   logic        aclk = 0, aresetn = 0, host_reset_n = 1, frame_take = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   // design outputs
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] rdata, mem_addr, mem_rdata, cycle_count;
   logic [1:0]  bresp, rresp;
   logic        mem_req, mem_ack, frame_ready, drained_irq;
   logic [31:0] lane_left [4];
   logic [31:0] lane_right [4];
   logic [31:0] d;
   logic [1:0]  r;
   int          error_cnt = 0, cmp_count = 0;
   always #2 aclk = ~aclk;
   aosd_dma uut (.aclk(aclk), .aresetn(aresetn),
      .host_reset_n(host_reset_n), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
      .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
      .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .frame_take(frame_take), .lane_left(lane_left),
      .lane_right(lane_right), .frame_ready(frame_ready),
      .drained_irq(drained_irq), .cycle_count(cycle_count));
   aosd_mem_model mem (.aclk(aclk), .aresetn(aresetn),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   // same byte-symmetric pattern as the memory model
   function automatic logic [31:0] pat(input logic [31:0] a);
      return {a[9:2], ~a[9:2], ~a[9:2], a[9:2]};
   endfunction
   // address of sample s with a 64-entry length
   function automatic logic [31:0] ad(input int s, input bit st);
      int bytes;
      bytes = st ? 512 : 256;
      return (s * 4 < bytes) ? B1 + s * 4 : B2 + s * 4 - bytes;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // write: address and data offered together, bready held to bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end
      while (!bvalid && n < 100);
      if (n >= 100) error_cnt++;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end
      while (!rvalid && n < 100);
      if (n >= 100) error_cnt++;
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic t_defaults;
      rd(aosd_pkg::OFF_CTRL);   chk(d, 32'h0000_0000);
      rd(aosd_pkg::OFF_STATUS); chk(d, 32'h0000_0001);
      rd(aosd_pkg::OFF_SECOND_BUFFER_BASE);  chk(d, 32'h0000_0000);
      rd(aosd_pkg::OFF_LENGTH); chk(d, 32'h0000_0000);
      rd(8'h40);
      chk(32'(r), 32'(aosd_pkg::AXI_SLVERR));
      chk(d, 32'h0000_0000);
   endtask
   // soft reset clears the unit only; host reset clears only the count
   task automatic t_resets;
      logic [31:0] c;
      wr(aosd_pkg::OFF_FIRST_BUFFER_BASE, B1);
      wr(aosd_pkg::OFF_CTRL, 32'h0000_0002);
      c = cycle_count;
      wr(aosd_pkg::OFF_CTRL, aosd_pkg::SOFT_RESET_WORD);
      rd(aosd_pkg::OFF_CTRL);  chk(d, 32'h0000_0000);
      rd(aosd_pkg::OFF_FIRST_BUFFER_BASE); chk(d, 32'h0000_0000);
      chk(32'(cycle_count > c), 32'h0000_0001);
      wr(aosd_pkg::OFF_FIRST_BUFFER_BASE, B1);
      host_reset_n <= 1'b0;
      repeat (2) @(posedge aclk);
      host_reset_n <= 1'b1;
      @(posedge aclk);
      chk(32'(cycle_count < 8), 32'h0000_0001);
      rd(aosd_pkg::OFF_FIRST_BUFFER_BASE); chk(d, B1);
   endtask
   task automatic stream(input int lanes, input bit st, input bit inv,
                         input int nf);
      logic [31:0] m, l, rr;
      int s, n;
      s = 0;
      m = inv ? 32'h8000_0000 : 32'h0000_0000;
      wr(aosd_pkg::OFF_CTRL, aosd_pkg::SOFT_RESET_WORD);
      wr(aosd_pkg::OFF_FIRST_BUFFER_BASE, B1);
      wr(aosd_pkg::OFF_SECOND_BUFFER_BASE, B2);
      // length of 64 entries, a legal multiple
      wr(aosd_pkg::OFF_LENGTH, 32'h0000_0040);
      repeat (5) @(posedge aclk);
      // enable only after both buffers are set, reserved bits zero
      wr(aosd_pkg::OFF_CTRL, 32'h0000_0081 | (32'(inv) << 2) |
         (32'(st) << 3) | (32'(lanes) << 5));
      repeat (nf)
      begin
         n = 0;
         do
         begin
            @(posedge aclk);
            n++;
         end
         while (!frame_ready && n < 200);
         if (n >= 200) error_cnt++;
         frame_take <= 1'b1;
         @(posedge aclk);
         frame_take <= 1'b0;
         @(posedge aclk);
         for (int i = 0; i < 4; i++)
         begin
            l  = m;
            rr = m;
            if (i <= lanes)
            begin
               l  = pat(ad(s, st)) ^ m;
               rr = st ? pat(ad(s + 1, st)) ^ m : l;
               s  = s + (st ? 2 : 1);
            end
            chk(lane_left[i], l);
            chk(lane_right[i], rr);
         end
      end
   endtask
   task automatic close_out;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_defaults;
      t_resets;
      stream(3, 1'b0, 1'b0, 20);
      rd(aosd_pkg::OFF_STATUS); chk(d, 32'h0000_0002);
      chk(32'(drained_irq), 32'h0000_0001);
      wr(aosd_pkg::OFF_CTRL, 32'h0000_02E1);
      rd(aosd_pkg::OFF_CTRL);   chk(d, 32'h0000_00E1);
      rd(aosd_pkg::OFF_STATUS); chk(d & 32'h2, 32'h0);
      chk(32'(drained_irq), 32'h0000_0000);
      stream(0, 1'b1, 1'b1, 4);
      close_out;
   end
   // watchdog well past the expected run length
   initial
   begin
      #200000;
      error_cnt++;
      close_out;
   end
endmodule
